// [common/fsw_pkg.sv]
`default_nettype none
package fsw_pkg;

  // ****************************************************************
  // instruction opcodes
  // ****************************************************************
  localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
  localparam logic [7:0] OP_BYTE_PROG         = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE      = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE     = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE     = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A      = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B      = 8'hc7;
  localparam logic [7:0] OP_AUTO_INC_PROG     = 8'had;

  // ****************************************************************
  // frame lengths in whole bytes, opcode included
  // ****************************************************************
  localparam logic [2:0] LEN_SHORT        = 3'h1;
  localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
  localparam logic [2:0] LEN_AUTO_NEXT    = 3'h3;
  localparam logic [2:0] LEN_ERASE        = 3'h4;
  localparam logic [2:0] LEN_PROG         = 3'h5;
  localparam logic [2:0] LEN_AUTO_FIRST   = 3'h6;
  localparam logic [2:0] LEN_SAT          = 3'h7;
  localparam logic [2:0] BIT_LAST         = 3'h7;

  // ****************************************************************
  // status register layout and power-up values
  // ****************************************************************
  localparam int         ST_BP_LO   = 2;
  localparam int         ST_BP_HI   = 5;
  localparam int         ST_LOCK    = 7;
  localparam logic [3:0] BP_RESET   = 4'h7;
  localparam logic [3:0] BP_CLEAR   = 4'h0;

  // ****************************************************************
  // protection bases (first protected address) and erase spans
  // ****************************************************************
  localparam logic [21:0] PROT_BASE_NONE = 22'h200000;
  localparam logic [21:0] PROT_BASE_1_32 = 22'h1f0000;
  localparam logic [21:0] PROT_BASE_1_16 = 22'h1e0000;
  localparam logic [21:0] PROT_BASE_1_8  = 22'h1c0000;
  localparam logic [21:0] PROT_BASE_1_4  = 22'h180000;
  localparam logic [21:0] PROT_BASE_1_2  = 22'h100000;
  localparam logic [21:0] PROT_BASE_ALL  = 22'h000000;
  localparam logic [21:0] AUTO_STEP      = 22'h000002;
  localparam logic [23:0] SPAN_SECTOR    = 24'h000fff;
  localparam logic [23:0] SPAN_BLOCK32   = 24'h007fff;
  localparam logic [23:0] SPAN_BLOCK64   = 24'h00ffff;
  localparam logic [23:0] SPAN_WORD      = 24'h000001;

  // ****************************************************************
  // host controller: serial clock divider and register map
  // ****************************************************************
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         SCK_PERIOD_NS = 80;
  localparam int         HALF_CYC      = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] HALF_LAST     = 5'(HALF_CYC - 1);
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_TX_HI     = 8'h04;
  localparam logic [7:0] REG_TX_LO     = 8'h08;
  localparam logic [7:0] REG_STAT      = 8'h0c;
  localparam logic [7:0] REG_CFG       = 8'h10;
  localparam int         CMD_START     = 16;

  typedef enum logic [2:0] {
    FSW_H_IDLE, FSW_H_LOW, FSW_H_HIGH, FSW_H_TRAIL, FSW_H_GAP
  } fsw_hstate_t;

endpackage : fsw_pkg
`default_nettype wire

// [common/fsw_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface fsw_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic wp_n;
  logic miso_o;
  logic miso_oe;
  wire  miso_line;

  // released output line reads high, as with a pull-up
  assign miso_line = miso_oe ? miso_o : 1'h1;

  modport device (input cs_n, sck, mosi, wp_n, output miso_o, miso_oe);
  modport host (output cs_n, sck, mosi, wp_n, input miso_line);
endinterface : fsw_if
`default_nettype wire

// [verilog/fsw_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module fsw_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : fsw_sync
`default_nettype wire

// [verilog/fsw_flash_dev.sv]
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - status bit 0 shows internal operation busy
// - while busy only status reads take effect
// - bit 1 is latch; latch low ignores writes
// - latch clears after write commands complete
// - bit 6 shows auto-increment mode, reset off
// - protected region refuses program and erase
// - three low level bits select region
// - power-up levels 111, other bits zero
// - status write updates levels when permitted
// - pin low and lock freeze lock, levels
// - whole-array erase needs all level bits zero
// - host sends write enable before writes
// - eight-bit cycles, most significant bit first
// - framing starts at select fall; rising sample
// - host frames commands; reads run until deselect
// - deselect mid-byte aborts without effect
// - sample rising, drive falling, both polarities
// - status read repeats until deselect
// - status write barred when pin low, locked
module fsw_flash_dev
  import fsw_pkg::*;
#(
  parameter int unsigned PROG_CYCLES  = 16,
  parameter int unsigned ERASE_CYCLES = 64
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  fsw_if.device            link,
  output logic             op_go_q,
  output logic [7:0]       op_code_q,
  output logic [23:0]      op_addr_q,
  output logic [7:0]       status_q
);

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic [3:0]  pins_s;
  logic        cs_n_s, sck_s, si_s, wp_n_s;
  logic        sck_d_q, cs_d_q, sel_q;
  logic        sck_rise, sck_fall, cs_rise, cs_fall;

  fsw_sync #(.WIDTH(4), .RST_VAL(4'h9)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     ({link.cs_n, link.sck, link.mosi, link.wp_n}),
    .dout    (pins_s)
  );

  assign cs_n_s   = pins_s[3];
  assign sck_s    = pins_s[2];
  assign si_s     = pins_s[1];
  assign wp_n_s   = pins_s[0];
  assign sck_rise = sel_q & ~cs_n_s & sck_s & ~sck_d_q;
  assign sck_fall = sel_q & ~cs_n_s & ~sck_s & sck_d_q;
  assign cs_rise  = cs_n_s & ~cs_d_q;
  assign cs_fall  = ~cs_n_s & cs_d_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_d_q <= 1'h0;
      cs_d_q  <= 1'h1;
      sel_q   <= 1'h0;
    end else begin
      sck_d_q <= sck_s;
      cs_d_q  <= cs_n_s;
      sel_q   <= cs_fall | (sel_q & ~cs_rise);
    end
  end

  // ****************************************************************
  // byte assembly
  // ****************************************************************
  logic [7:0]  shift_q, new_byte, opcode_q;
  logic [2:0]  bit_cnt_q, byte_cnt_q;
  logic [47:0] args_q;
  logic        byte_done;

  assign new_byte  = {shift_q[6:0], si_s};
  assign byte_done = sck_rise & (bit_cnt_q == BIT_LAST);

  always_ff @(posedge clock) begin
    if (sys_rst | cs_fall) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q   <= new_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done && byte_cnt_q != LEN_SAT) begin
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opcode_q <= 8'h00;
      args_q   <= 48'h0;
    end else if (byte_done) begin
      if (byte_cnt_q == 3'h0) begin
        opcode_q <= new_byte;
      end
      args_q <= {args_q[39:0], new_byte};
    end
  end

  // ****************************************************************
  // status bits, protection decode, command qualification
  // ****************************************************************
  logic        wel_q, auto_q, lock_q, busy;
  logic [3:0]  bp_q;
  logic [15:0] busy_cnt_q;
  logic [23:0] auto_addr_q, cmd_addr, cmd_span, prog_addr;
  logic [21:0] prot_base, cmd_last, auto_next;
  logic [7:0]  status_d;
  logic        frame_ok, is_erase, is_chip, in_prot, status_write_cmd_ok;
  logic        ex_write_enable_cmd, ex_write_disable_cmd, ex_status_write_cmd, wr_done;
  logic        ex_prog, ex_erase, ex_chip, auto_first, auto_more, auto_go, auto_stop;

  assign busy     = busy_cnt_q != 16'h0;
  assign status_d = {lock_q, auto_q, bp_q, wel_q, busy};

  always_comb begin
    case (bp_q[2:0])
      3'h0:    prot_base = PROT_BASE_NONE;
      3'h1:    prot_base = PROT_BASE_1_32;
      3'h2:    prot_base = PROT_BASE_1_16;
      3'h3:    prot_base = PROT_BASE_1_8;
      3'h4:    prot_base = PROT_BASE_1_4;
      3'h5:    prot_base = PROT_BASE_1_2;
      default: prot_base = PROT_BASE_ALL;
    endcase
  end

  assign is_erase = (opcode_q == OP_SECTOR_ERASE) | (opcode_q == OP_BLOCK32_ERASE)
                  | (opcode_q == OP_BLOCK64_ERASE);
  assign is_chip  = (opcode_q == OP_CHIP_ERASE_A) | (opcode_q == OP_CHIP_ERASE_B);
  assign cmd_addr = (opcode_q == OP_BYTE_PROG)     ? args_q[31:8]  :
                    (opcode_q == OP_AUTO_INC_PROG) ? args_q[39:16] : args_q[23:0];
  assign cmd_span = (opcode_q == OP_SECTOR_ERASE)  ? SPAN_SECTOR  :
                    (opcode_q == OP_BLOCK32_ERASE) ? SPAN_BLOCK32 :
                    (opcode_q == OP_BLOCK64_ERASE) ? SPAN_BLOCK64 :
                    (opcode_q == OP_AUTO_INC_PROG) ? SPAN_WORD    : 24'h0;
  assign cmd_last = {1'h0, cmd_addr[20:0] | cmd_span[20:0]};
  assign in_prot  = cmd_last >= prot_base;

  // partial byte at deselect does nothing
  // busy blocks all but status read
  assign frame_ok = cs_rise & sel_q & (bit_cnt_q == 3'h0) & ~busy;
  // barred with pin low and lock set
  assign status_write_cmd_ok  = wp_n_s | ~lock_q;

  assign ex_write_enable_cmd  = frame_ok & (opcode_q == OP_WRITE_ENABLE_CMD) & (byte_cnt_q == LEN_SHORT);
  assign ex_write_disable_cmd  = frame_ok & (opcode_q == OP_WRITE_DISABLE_CMD) & (byte_cnt_q == LEN_SHORT);
  assign ex_status_write_cmd  = frame_ok & (opcode_q == OP_STATUS_WRITE_CMD)
                  & (byte_cnt_q == LEN_STATUS_WRITE);
  assign ex_prog  = frame_ok & (opcode_q == OP_BYTE_PROG) & (byte_cnt_q == LEN_PROG)
                  & wel_q & ~auto_q & ~in_prot;
  assign ex_erase = frame_ok & is_erase & (byte_cnt_q == LEN_ERASE) & wel_q & ~auto_q & ~in_prot;
  assign ex_chip  = frame_ok & is_chip & (byte_cnt_q == LEN_SHORT) & wel_q & ~auto_q
                  & (bp_q == BP_CLEAR);
  assign wr_done  = frame_ok & (((opcode_q == OP_BYTE_PROG) & (byte_cnt_q == LEN_PROG))
                  | (is_erase & (byte_cnt_q == LEN_ERASE)) | (is_chip & (byte_cnt_q == LEN_SHORT)));

  assign auto_first = frame_ok & (opcode_q == OP_AUTO_INC_PROG) & ~auto_q
                    & (byte_cnt_q == LEN_AUTO_FIRST) & wel_q & ~in_prot;
  assign auto_more  = frame_ok & (opcode_q == OP_AUTO_INC_PROG) & auto_q
                    & (byte_cnt_q == LEN_AUTO_NEXT);
  assign auto_go    = auto_first | auto_more;
  assign prog_addr  = auto_q ? auto_addr_q : {cmd_addr[23:1], 1'h0};
  assign auto_next  = {1'h0, prog_addr[20:0]} + AUTO_STEP;
  assign auto_stop  = auto_go & (auto_next >= prot_base);

  // ****************************************************************
  // status register state
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bp_q   <= BP_RESET;
      lock_q <= 1'h0;
    end else if (ex_status_write_cmd && status_write_cmd_ok && wel_q) begin
      // frozen while pin low and locked
      bp_q   <= args_q[ST_BP_HI:ST_BP_LO];
      lock_q <= args_q[ST_LOCK];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wel_q <= 1'h0;
    end else if (ex_write_disable_cmd | ex_status_write_cmd | wr_done | auto_stop) begin
      wel_q <= 1'h0;
    end else if (ex_write_enable_cmd) begin
      wel_q <= 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      auto_q      <= 1'h0;
      auto_addr_q <= 24'h0;
    end else if (ex_write_disable_cmd | auto_stop) begin
      auto_q <= 1'h0;
    end else if (auto_go) begin
      auto_q      <= 1'h1;
      auto_addr_q <= {prog_addr[23:21], auto_next[20:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_cnt_q <= 16'h0;
    end else if (ex_prog | auto_go) begin
      busy_cnt_q <= 16'(PROG_CYCLES);
    end else if (ex_erase | ex_chip) begin
      busy_cnt_q <= 16'(ERASE_CYCLES);
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q - 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op_go_q   <= 1'h0;
      op_code_q <= 8'h00;
      op_addr_q <= 24'h0;
      status_q  <= 8'h00;
    end else begin
      op_go_q  <= ex_prog | ex_erase | ex_chip | auto_go;
      status_q <= status_d;
      if (ex_prog | ex_erase | ex_chip | auto_go) begin
        op_code_q <= opcode_q;
        op_addr_q <= (ex_prog | auto_go) ? prog_addr : cmd_addr;
      end
    end
  end

  // ****************************************************************
  // status read output
  // ****************************************************************
  logic       rd_q, miso_q, miso_oe_q;
  logic [7:0] out_q;
  logic [2:0] out_idx_q;

  assign link.miso_o  = miso_q;
  assign link.miso_oe = miso_oe_q;

  always_ff @(posedge clock) begin
    if (sys_rst | cs_rise | cs_fall) begin
      rd_q      <= 1'h0;
      miso_oe_q <= 1'h0;
      out_idx_q <= BIT_LAST;
    end else begin
      if (byte_done && byte_cnt_q == 3'h0 && new_byte == OP_STATUS_READ_CMD) begin
        rd_q <= 1'h1;
      end
      if (sck_fall && rd_q) begin
        miso_oe_q <= 1'h1;
        out_idx_q <= out_idx_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      miso_q <= 1'h0;
      out_q  <= 8'h00;
    end else if (sck_fall && rd_q) begin
      if (out_idx_q == BIT_LAST) begin
        miso_q <= status_d[BIT_LAST];
        out_q  <= {status_d[6:0], 1'h0};
      end else begin
        miso_q <= out_q[BIT_LAST];
        out_q  <= {out_q[6:0], 1'h0};
      end
    end
  end

endmodule : fsw_flash_dev
`default_nettype wire

// [verilog/fsw_host.sv]
`timescale 1ns/1ns
`default_nettype none
module fsw_host
  import fsw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  fsw_if.host              link
);

  // ****************************************************************
  // register access
  // ****************************************************************
  logic        wr_fire, start, active_q, wp_q, cs_n_q, sck_q;
  logic [14:0] cmd_q;
  logic [31:0] tx_hi_q, tx_lo_q, rd_mux;
  logic [7:0]  rx_q;
  logic        miso_s;

  assign wr_fire = psel & penable & pready & pwrite;
  assign start   = wr_fire & (paddr == REG_CMD) & pwdata[CMD_START] & ~active_q;
  assign rd_mux  = (paddr == REG_CMD)   ? {17'h0, cmd_q} :
                   (paddr == REG_TX_HI) ? tx_hi_q :
                   (paddr == REG_TX_LO) ? tx_lo_q :
                   (paddr == REG_STAT)  ? {16'h0, rx_q, 7'h0, active_q} :
                   (paddr == REG_CFG)   ? {31'h0, wp_q} : 32'h0;

  // one wait state: answer on the second access cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // writes are refused while a frame runs so it cannot change underfoot
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_q   <= 15'h0;
      tx_hi_q <= 32'h0;
      tx_lo_q <= 32'h0;
      wp_q    <= 1'h1;
    end else if (wr_fire && !active_q) begin
      if (paddr == REG_CMD)   cmd_q   <= pwdata[14:0];
      if (paddr == REG_TX_HI) tx_hi_q <= pwdata;
      if (paddr == REG_TX_LO) tx_lo_q <= pwdata;
      if (paddr == REG_CFG)   wp_q    <= pwdata[0];
    end
  end

  // ****************************************************************
  // serial engine: mode 0, clock made by divider
  // ****************************************************************
  fsw_hstate_t state_q;
  logic [4:0]  div_q;
  logic [7:0]  bits_q, bits_d;
  logic [71:0] out_q;
  logic        tick;

  fsw_sync #(.WIDTH(1), .RST_VAL(1'h1)) u_sync (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (link.miso_line),
    .dout    (miso_s)
  );

  assign tick        = div_q == HALF_LAST;
  // opcode, then bytes, all msb first
  assign bits_d      = 8'h08 + {2'h0, pwdata[10:8], 3'h0} + {1'h0, pwdata[14:11], 3'h0};
  assign link.cs_n   = cs_n_q;
  assign link.sck    = sck_q;
  assign link.mosi   = out_q[71];
  assign link.wp_n   = wp_q;

  always_ff @(posedge clock) begin
    if (sys_rst || state_q == FSW_H_IDLE || tick) begin
      div_q <= 5'h0;
    end else begin
      div_q <= div_q + 5'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q  <= FSW_H_IDLE;
      active_q <= 1'h0;
      cs_n_q   <= 1'h1;
      sck_q    <= 1'h0;
      bits_q   <= 8'h0;
      out_q    <= 72'h0;
      rx_q     <= 8'h0;
    end else begin
      case (state_q)
        FSW_H_IDLE: begin
          if (start) begin
            active_q <= 1'h1;
            cs_n_q   <= 1'h0;
            bits_q   <= bits_d;
            out_q    <= {pwdata[7:0], tx_hi_q, tx_lo_q};
            state_q  <= FSW_H_LOW;
          end
        end
        FSW_H_LOW: begin
          if (tick) begin
            sck_q   <= 1'h1;
            rx_q    <= {rx_q[6:0], miso_s};
            state_q <= FSW_H_HIGH;
          end
        end
        FSW_H_HIGH: begin
          if (tick) begin
            sck_q   <= 1'h0;
            bits_q  <= bits_q - 8'h1;
            out_q   <= {out_q[70:0], 1'h0};
            state_q <= (bits_q == 8'h1) ? FSW_H_TRAIL : FSW_H_LOW;
          end
        end
        FSW_H_TRAIL: begin
          // deselect half a serial clock period after the last bit
          if (tick) begin
            cs_n_q  <= 1'h1;
            state_q <= FSW_H_GAP;
          end
        end
        FSW_H_GAP: begin
          if (tick) begin
            active_q <= 1'h0;
            state_q  <= FSW_H_IDLE;
          end
        end
        default: state_q <= FSW_H_IDLE;
      endcase
    end
  end

endmodule : fsw_host
`default_nettype wire

// [bench/fsw_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module fsw_sva
  import fsw_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       wp_n,
  input wire logic       miso_oe,
  input wire logic       op_go_q,
  input wire logic [7:0] op_code_q,
  input wire logic [7:0] status_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // status byte against accepted operations
  // ****************************************************************
  reset_value_a: assert property ($fell(sys_rst) |-> ##[0:1] status_q == 8'h1c)
    else $error("status not at power-up value");
  // wel was set and device idle well before the accepting edge
  go_needs_wel_a: assert property (op_go_q |-> $past(status_q[1], 2) && !$past(status_q[0], 2))
    else $error("operation accepted without latch or while busy");
  busy_after_go_a: assert property (op_go_q |->
      ##[0:2] (status_q[0] && (!status_q[1] || status_q[6])))
    else $error("busy not set or latch not cleared");
  busy_hold_a: assert property ($rose(status_q[0]) |=> status_q[0] [*8])
    else $error("busy dropped early");
  lock_freeze_a: assert property (!wp_n && status_q[7] |=>
      $stable({status_q[7], status_q[5:2]}))
    else $error("locked protection bits changed");
  erase_bp_a: assert property (op_go_q && (op_code_q == OP_CHIP_ERASE_A ||
      op_code_q == OP_CHIP_ERASE_B) |-> $past(status_q[5:2], 2) == 4'h0)
    else $error("whole erase with protection set");
  // ****************************************************************
  // link idle levels
  // ****************************************************************
  miso_idle_a: assert property (cs_n [*5] |-> !miso_oe)
    else $error("output driven while deselected");
  sck_idle_a: assert property (cs_n [*2] |-> !sck)
    else $error("serial clock not idle low");
  cover property (op_go_q);
  cover property (!wp_n && status_q[7]);
  cover property (miso_oe && !cs_n);
  cover property (status_q[6]);
endmodule : fsw_sva
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top import fsw_pkg::*;;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        op_go_q;
  logic [7:0]  op_code_q;
  logic [7:0]  status_q;
  logic [23:0] op_addr_q;
  logic [31:0] rd;
  logic [31:0] seed = 32'h00005930;
  logic [21:0] bases [8] = '{PROT_BASE_NONE, PROT_BASE_1_32, PROT_BASE_1_16, PROT_BASE_1_8,
                             PROT_BASE_1_4, PROT_BASE_1_2, PROT_BASE_ALL, PROT_BASE_ALL};
  int          mismatches = 0;
  int          n_tests = 0;
  int          bp = 7, lock = 0, write_enable_latch = 0, busy = 0, gos = 0, ngo = 0, wp = 1, inc = 0;

  fsw_if link ();
  always #2 clock = ~clock;
  always @(posedge clock) if (op_go_q === 1'b1) ngo <= ngo + 1;

  fsw_host u_fsw_host (.clock(clock), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .link(link));
  // long busy spans so status can be polled while an operation runs
  fsw_flash_dev #(.PROG_CYCLES(2000), .ERASE_CYCLES(2000)) u_fsw_flash_dev (.clock(clock),
    .sys_rst(sys_rst), .link(link), .op_go_q(op_go_q), .op_code_q(op_code_q),
    .op_addr_q(op_addr_q), .status_q(status_q));
  fsw_sva u_fsw_sva (.clock(clock), .sys_rst(sys_rst), .cs_n(link.cs_n), .sck(link.sck),
    .wp_n(link.wp_n), .miso_oe(link.miso_oe), .op_go_q(op_go_q), .op_code_q(op_code_q),
    .status_q(status_q));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ****************************************************************
  // one serial frame, then its effect on the reference status
  // ****************************************************************
  task automatic frame(input logic [7:0] op, input logic [2:0] n, input logic [31:0] hi);
    apb(1'b1, REG_TX_HI, hi);
    apb(1'b1, REG_CMD, {15'h0, 1'b1, 1'b0, 4'(op == OP_STATUS_READ_CMD), n, op});
    do apb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
    if (busy == 0) begin
      case (op)
        OP_WRITE_ENABLE_CMD: write_enable_latch = 1;
        OP_WRITE_DISABLE_CMD: begin
          write_enable_latch = 0;
          inc = 0;
        end
        OP_STATUS_READ_CMD: ;
        OP_AUTO_INC_PROG: if (write_enable_latch == 1) begin
          inc = 1;
          busy = 1;
          gos++;
        end
        OP_STATUS_WRITE_CMD: if (write_enable_latch == 1) begin
          if (wp == 1 || lock == 0) begin
            bp = hi[29:26];
            lock = hi[31];
          end
          write_enable_latch = 0;
        end
        default: if (write_enable_latch == 1) begin
          if ((op == OP_BYTE_PROG && hi[29:8] < bases[bp[2:0]]) || bp == 0) begin
            busy = 1;
            gos++;
          end
          write_enable_latch = 0;
        end
      endcase
    end
  endtask : frame

  task automatic rdst;
    frame(OP_STATUS_READ_CMD, 3'h0, 32'h0);
    apb(1'b0, REG_STAT, 32'h0);
    check(32'(rd[15:8]), 32'({lock[0], inc[0], bp[3:0], write_enable_latch[0], busy[0]}));
  endtask : rdst

  task automatic settle;
    repeat (2100) @(posedge clock);
    busy = 0;
  endtask : settle

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    rdst();
    frame(OP_WRITE_DISABLE_CMD, 3'h0, 32'h0);
    rdst();
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wp = (i % 3 != 2);
      apb(1'b1, REG_CFG, 32'(wp));
      frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
      frame(OP_STATUS_WRITE_CMD, 3'h1,
            {(seed[31:24] & 8'hbc) | ((i == 3 || i == 4) ? 8'h80 : 8'h00), 24'h0});
      rdst();
    end
    wp = 1;
    apb(1'b1, REG_CFG, 32'h1);
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_STATUS_WRITE_CMD, 3'h1, 32'h0400_0000);
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_BYTE_PROG, 3'h4, 32'h1f00_1055);
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_BYTE_PROG, 3'h4, 32'h0001_0055);
    check(32'(op_addr_q), 32'h0000_0100);
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    rdst();
    settle();
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_CHIP_ERASE_A, 3'h0, 32'h0);
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_STATUS_WRITE_CMD, 3'h1, 32'h0);
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_AUTO_INC_PROG, 3'h5, 32'h0000_1055);
    check(32'(op_addr_q), 32'h0000_0010);
    rdst();
    settle();
    frame(OP_WRITE_DISABLE_CMD, 3'h0, 32'h0);
    rdst();
    frame(OP_WRITE_ENABLE_CMD, 3'h0, 32'h0);
    frame(OP_CHIP_ERASE_B, 3'h0, 32'h0);
    settle();
    // status write without the latch must not land
    frame(OP_STATUS_WRITE_CMD, 3'h1, 32'h3c00_0000);
    rdst();
    check(32'(ngo), 32'(gos));
    print_verdict();
  end

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
